// ---- core/clagi_core.sv ----
// Address pointer, glyph/icon memories and panel scan for the character LCD.
// Assumes bus inputs are already synchronous to clk_sys; command decode is upstream.
// The fixed glyph ROM sits outside and answers rom_code_row on rom_row in the same cycle.
// How it works
// - Address-set command loads the pointer from the command holding register.
// - Each RAM read or write steps the pointer by one, except when an address set comes in the same cycle.
// - Status read with select low and read high shows pointer on low lines.
// - Cursor, blink and inversion of the character at the cursor position.
// - Panel driven through 34 commons and 80 segments.
// - Pattern data shifts serially into 80-bit latch, then moves to a holding latch.
// - One common active at a time; segments driven from the holding latch.
// - Two-line mode scans eighteen rows, commons 0..16 plus the icon row, 1/18 duty.
// - Four-line mode scans all 34 rows, commons 0..32 plus the icon row, 1/34 duty.
// - Eight user 5x8 glyphs stored in glyph RAM.
// - Glyph address is code bits 2..0 over row number.
// - Glyph byte: two blink bits, bit 5 ignored, five dot bits.
// - Blink attributes act only while blink enable is high.
// - Upper select bit set blinks whole glyph row.
// - Only lower bit set marks P5, which no dot shows, so nothing blinks; both clear, none.
// - Two icon commons carry identical waveforms.
// - Icon byte: two blink bits, bit 5 unused, five pattern bits.
// - Icon address n bits 4..0 map to segments 5n+1 to 5n+5.
// - Icon blink: upper set all five, 01 only bit 4, 00 none.
// - Busy reads high on bit 7 of status.
// - Entry direction high increments, low decrements, for all RAMs.
`timescale 1ns/1ps
`default_nettype none
module clagi_core
    import clagi_pkg::*;
(
    input  wire logic                          clk_sys,
    input  wire logic                          rst,
    // Host bus and decoded command
    input  wire clagi_pkg::clagi_bus_s         bus,
    input  wire clagi_pkg::clagi_cmd_s         cmd,
    // Mode and display levels
    input  wire logic                          entry_inc,
    input  wire logic                          busy,
    input  wire logic                          four_line,
    input  wire logic                          blink_enable_bit,
    input  wire logic                          cursor_on,
    input  wire logic                          cursor_blink,
    // Fixed glyph ROM lookup and host read data
    input  wire logic [7:0]                    rom_row,
    output logic [6:0]                         rom_code_row,
    output logic [7:0]                         read_data,
    // Panel drive
    output logic [CLAGI_COM_N-1:0]             com_line,
    output logic [1:0]                         icon_com,
    output logic [CLAGI_SEG_N-1:0]             segment_line
);
    import clagi_pkg::*;

    // Target memories; text codes are 8-bit character codes
    // Glyph and icon arrays are indexed by the low pointer bits only
    logic [7:0]          text_code_ram    [CLAGI_TEXT_N];
    logic [7:0]          user_glyph_ram   [CLAGI_GLYPH_N];
    logic [7:0]          icon_pattern_ram [CLAGI_ICON_N];
    logic [6:0]          ram_address_pointer;
    clagi_tgt_e          tgt;
    logic [7:0]          rd_q;
    logic                blink_phase;
    logic [5:0]          blink_cnt;

    // Pointer step; wraps within seven bits in both directions
    function automatic logic [6:0] step_addr(input logic [6:0] a, input logic inc);
        step_addr = inc ? a + 7'h01 : a - 7'h01;
    endfunction : step_addr

    // Row blink mask for a glyph or icon byte; top is the single-dot position
    // Glyphs pass P5 as the single dot and icons pass D4; with blink off the mask stays empty
    function automatic logic [5:0] blink_mask(input logic [7:0] b, input logic en, input int top);
        logic [5:0] m;
        m = 6'h00;
        if (en && b[CLAGI_BLINK_UP])
            m = (top == 5) ? 6'h3F : 6'h1F;
        else if (en && b[CLAGI_BLINK_LO])
            m = 6'h01 << top;
        blink_mask = m;
    endfunction : blink_mask

    // Request decode: select high is a data access, select low with read high a status read
    wire ram_data_acc = bus.strobe && bus.rs;
    wire status_rd    = bus.strobe && !bus.rs && bus.rw;

    // Pointer: load on address set, step on every data access
    // A same-cycle address set wins and the step of that access is lost
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            // Reset points at text address zero
            ram_address_pointer <= CLAGI_ADDR_RST;
            tgt                 <= CLAGI_TGT_TEXT;
        end
        else if (cmd.set_addr)
        begin
            // The target follows the address so later accesses go to the same memory
            ram_address_pointer <= cmd.addr;
            tgt                 <= cmd.tgt;
        end
        else if (ram_data_acc)
            ram_address_pointer <= step_addr(ram_address_pointer, entry_inc);
    end

    // Host writes to the selected memory; no reset so the arrays stay RAM-like
    // A write beside an address set still lands at the old pointer
    always_ff @(posedge clk_sys)
    begin
        if (ram_data_acc && !bus.rw)
        begin
            unique case (tgt)
                CLAGI_TGT_TEXT:  text_code_ram[ram_address_pointer] <= bus.data;
                CLAGI_TGT_GLYPH: user_glyph_ram[ram_address_pointer[5:0]] <= bus.data;
                CLAGI_TGT_ICON:  icon_pattern_ram[ram_address_pointer[3:0]] <= bus.data;
                default:         ; // Illegal target code: the write is dropped
            endcase
        end
    end

    // Read data is registered; status shows busy and pointer
    // A status read never steps the pointer; read data stands until the next read
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            rd_q <= 8'h00;
        else if (status_rd)
            rd_q <= {busy, ram_address_pointer};
        else if (ram_data_acc && bus.rw)
        begin
            unique case (tgt)
                CLAGI_TGT_TEXT:  rd_q <= text_code_ram[ram_address_pointer];
                CLAGI_TGT_GLYPH: rd_q <= user_glyph_ram[ram_address_pointer[5:0]];
                CLAGI_TGT_ICON:  rd_q <= icon_pattern_ram[ram_address_pointer[3:0]];
                default:         rd_q <= 8'h00;
            endcase
        end
    end
    assign read_data = rd_q;

    // Scan state: load the shift latch during one phase, show during the next
    // Each counter moves only in its own phase; the last load cycle clears both pos and sub_cnt
    clagi_scan_e         sc;
    logic [7:0]          sub_cnt;
    logic [5:0]          row;          // 0..33, 33 reserved as icon row in 4-line mode
    logic [6:0]          pos;          // segment bit being shifted, 0..79
    logic [CLAGI_SEG_N-1:0] shift_latch;
    logic [CLAGI_SEG_N-1:0] hold_latch;
    logic [5:0]          shown_row;
    logic                shown_valid;

    // Scan geometry: the last row of the duty is the icon row, the rows below it text
    // In two-line mode rows 0..16 are text; in four-line mode rows 0..32
    wire [5:0] last_row   = four_line ? 6'(CLAGI_COM_N - 1) : 6'(CLAGI_COM_2L - 1);
    wire       icon_row   = (row == last_row);

    // Character row within a band of nine commons (eight dots plus a gap)
    wire [5:0] band       = row / 6'h09;
    wire [3:0] in_band    = 4'(row % 6'h09);
    wire [3:0] col        = 4'(pos / 7'h05);
    wire [2:0] dot        = 3'(pos % 7'h05);

    // Text fetch: each band starts a new line of 32 text addresses
    // Only the low two band bits matter; four bands at most
    wire [6:0] text_addr  = {band[1:0], 5'h00} | {3'h0, col};
    wire [7:0] code       = text_code_ram[text_addr];
    wire       user_code  = (code[7:3] == 5'h00);

    // User glyph fetch; code bits 7..3 all clear select a user glyph
    // A glyph row byte carries its own blink attribute in the top two bits
    wire [5:0] glyph_addr = {code[2:0], in_band[2:0]};
    wire [7:0] glyph_byte = user_glyph_ram[glyph_addr];

    // Icon fetch: one icon byte covers five segments
    // Bit 5 of an icon byte is never shifted out
    wire [7:0] icon_byte  = icon_pattern_ram[col];

    // Cursor sits on the text cell that the pointer names
    wire       at_cursor  = (tgt == CLAGI_TGT_TEXT) && (text_addr == ram_address_pointer);

    // Fixed glyph ROM address: code folded to four bits over the dot row
    assign     rom_code_row = {code[6:3] ^ {1'b0, code[2:0]}, in_band[2:0]};

    // Dot bit before blink: bit 4 of a row byte is the leftmost dot
    wire [7:0] row_byte   = user_code ? glyph_byte : rom_row;

    // Blink masks; ROM glyphs carry no attribute bits
    wire [5:0] g_mask     = user_code ? blink_mask(glyph_byte, blink_enable_bit, 5) : 6'h00;
    wire [5:0] i_mask     = blink_mask(icon_byte, blink_enable_bit, CLAGI_ICON_TOP);
    wire       g_dot      = row_byte[3'd4 - dot] && !(g_mask[3'd4 - dot] && blink_phase);
    wire       i_dot      = icon_byte[3'd4 - dot] && !(i_mask[3'd4 - dot] && blink_phase);

    // Cursor: underline on dot row 7, and the blink phase inverts the whole cell
    wire       gap_row    = (in_band == 4'h8);
    wire       cur_line   = cursor_on && (in_band == 4'h7);
    wire       cur_inv    = cursor_blink && blink_phase;

    // Gap rows stay dark; the serial bit picks icon or text by row
    wire       text_bit   = gap_row ? 1'b0 : ((g_dot | (at_cursor & cur_line)) ^ (at_cursor & cur_inv));
    wire       next_bit   = icon_row ? i_dot : text_bit;

    // Blink phase toggles every 64 frames
    // A phase spans whole frames, so the blink rate follows the duty setting
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            blink_cnt   <= 6'h00;
            blink_phase <= 1'b0;
        end
        else if (sc == CLAGI_SC_SHOW && sub_cnt == CLAGI_ROW_CYC && row == last_row)
        begin
            blink_cnt <= blink_cnt + 6'h01;
            if (blink_cnt == 6'(CLAGI_BLINK_ROWS - 1))
                blink_phase <= !blink_phase;
        end
    end

    // Scan sequencer: the next row is fully shifted before it is shown
    // Trade-off: the panel is dark for the 80 load cycles of every row
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            sc          <= CLAGI_SC_LOAD;
            sub_cnt     <= 8'h00;
            row         <= 6'h00;
            pos         <= 7'h00;
            shift_latch <= '0;
            hold_latch  <= '0;
            shown_row   <= 6'h00;
            shown_valid <= 1'b0;
        end
        else
        begin
            unique case (sc)
                CLAGI_SC_LOAD:
                begin
                    // One dot per clock; segment 1 goes in first and ends at the top bit
                    shift_latch <= {shift_latch[CLAGI_SEG_N-2:0], next_bit};
                    pos         <= pos + 7'h01;
                    if (pos == 7'(CLAGI_SEG_N - 1))
                    begin
                        // The last dot goes straight into the holding latch with the rest
                        hold_latch  <= {shift_latch[CLAGI_SEG_N-2:0], next_bit};
                        shown_row   <= row;
                        shown_valid <= 1'b1;
                        pos         <= 7'h00;
                        sub_cnt     <= 8'h00;
                        sc          <= CLAGI_SC_SHOW;
                    end
                end
                CLAGI_SC_SHOW:
                begin
                    // Hold the row for the programmed count, then load the next one
                    sub_cnt <= sub_cnt + 8'h01;
                    if (sub_cnt == CLAGI_ROW_CYC)
                    begin
                        row <= (row >= last_row) ? 6'h00 : row + 6'h01;
                        sc  <= CLAGI_SC_LOAD;
                    end
                end
            endcase
        end
    end

    // Outputs: one common at a time; the icon row is driven on both icon pins
    // Nothing is shown until the first row has reached the holding latch
    wire show      = shown_valid && (sc == CLAGI_SC_SHOW);
    wire show_icon = show && (shown_row == last_row);

    // Common select; a one-hot shift keeps a single line on at any time
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            com_line <= '0;
        else
            com_line <= (show && !show_icon) ? (CLAGI_COM_N'(1) << shown_row) : '0;
    end

    // Both icon pins take one term, so they can never differ
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            icon_com <= 2'b00;
        else
            icon_com <= {2{show_icon}};
    end

    // Segments blank between rows so a stale latch never reaches the next common
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            segment_line <= '0;
        else
            segment_line <= show ? hold_latch : '0;
    end
endmodule : clagi_core
`default_nettype wire

// ---- core/clagi_pkg.sv ----
// Package for the character LCD address, glyph and icon datapath.
// Assumes a single 25 MHz system clock and no register bus.
package clagi_pkg;
    localparam int          CLAGI_CLK_HZ      = 25000000;
    localparam int          CLAGI_SEG_N       = 80;
    localparam int          CLAGI_COM_N       = 34;
    localparam int          CLAGI_COM_2L      = 18;
    localparam int          CLAGI_ICON_N      = 16;
    localparam int          CLAGI_GLYPH_N     = 64;
    localparam int          CLAGI_TEXT_N      = 128;
    localparam logic [6:0]  CLAGI_ADDR_RST    = 7'h00;
    localparam logic [7:0]  CLAGI_ROW_CYC     = 8'hC7;
    localparam int          CLAGI_BLINK_ROWS  = 64;
    localparam int          CLAGI_BLINK_UP    = 7;
    localparam int          CLAGI_BLINK_LO    = 6;
    localparam int          CLAGI_ICON_TOP    = 4;
    localparam logic [7:0]  CLAGI_SPACE       = 8'h20;

    typedef enum logic [2:0]
    {
        CLAGI_TGT_TEXT  = 3'b001,
        CLAGI_TGT_GLYPH = 3'b010,
        CLAGI_TGT_ICON  = 3'b100
    } clagi_tgt_e;

    typedef enum logic [1:0]
    {
        CLAGI_SC_LOAD = 2'b01,
        CLAGI_SC_SHOW = 2'b10
    } clagi_scan_e;

    typedef struct packed
    {
        logic       rs;
        logic       rw;
        logic       strobe;
        logic [7:0] data;
    } clagi_bus_s;

    typedef struct packed
    {
        logic       set_addr;
        clagi_tgt_e tgt;
        logic [6:0] addr;
    } clagi_cmd_s;
endpackage : clagi_pkg

// ---- tb/clagi_core_tb_top.sv ----
// Self-checking bench for clagi_core with a host model.
// Assumes reads answer one cycle after the strobe edge.
`timescale 1ns/1ps
`default_nettype none
module clagi_core_tb_top;
    import clagi_pkg::*;
    logic clk_sys = 1'b0, rst = 1'b1, entry_inc = 1'b1, busy = 1'b0, four_line = 1'b0;
    logic blink_enable_bit = 1'b0, cursor_on = 1'b0, cursor_blink = 1'b0, pend = 1'b0;
    logic [7:0] rom_row = 8'h00, read_data, exp_q[$], mem[3][128];
    logic [6:0] rom_code_row, ptr, a;
    logic [33:0] com_line;
    logic [1:0] icon_com;
    logic [79:0] segment_line, want;
    clagi_bus_s bus;
    clagi_cmd_s cmd;
    int num_errors = 0, n_compared = 0, cyc = 0, tg, j, m;
    clagi_host_model host (.clk_sys(clk_sys), .bus(bus), .cmd(cmd));
    clagi_core i_clagi_core (.clk_sys(clk_sys), .rst(rst), .bus(bus), .cmd(cmd), .entry_inc(entry_inc),
        .busy(busy), .four_line(four_line), .blink_enable_bit(blink_enable_bit), .cursor_on(cursor_on),
        .cursor_blink(cursor_blink), .rom_row(rom_row), .rom_code_row(rom_code_row), .read_data(read_data),
        .com_line(com_line), .icon_com(icon_com), .segment_line(segment_line));
    initial forever #20 clk_sys = ~clk_sys;
    task automatic stop_test;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic step;
        ptr = entry_inc ? ptr + 7'h01 : ptr - 7'h01;
    endtask : step
    task automatic setp(input int t, input logic [6:0] ad);
        tg = t;
        ptr = ad;
        host.set_ptr(t == 0 ? CLAGI_TGT_TEXT : t == 1 ? CLAGI_TGT_GLYPH : CLAGI_TGT_ICON, ad);
    endtask : setp
    task automatic wr(input logic [7:0] d);
        mem[tg][ptr] = d;
        step();
        host.access(1'b1, 1'b0, d);
    endtask : wr
    task automatic rd;
        exp_q.push_back(mem[tg][ptr]);
        step();
        host.access(1'b1, 1'b1, 8'h00);
    endtask : rd
    task automatic st;
        exp_q.push_back({busy, ptr});
        host.access(1'b0, 1'b1, 8'h00);
    endtask : st
    // Answers are taken in request order, one cycle after each read
    always @(posedge clk_sys) pend <= bus.strobe && bus.rw && !cmd.set_addr && !rst;
    always @(negedge clk_sys) if (pend) chk(read_data, exp_q.pop_front());
    // Guard against a hang in any wait
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            num_errors++;
            stop_test();
        end
    end
    initial
    begin
        void'($urandom(32'h2a826402));
        for (m = 0; m < 2; m++)
        begin
            rst = 1'b1;
            four_line = m[0];
            rom_row = 8'($urandom);
            repeat (12) @(posedge clk_sys);
            #1 rst = 1'b0;
            ptr = 7'h00;
            tg = 0;
            st();
            chk(rom_code_row[2:0], 3'h0);
            busy = 1'b1;
            st();
            busy = 1'b0;
            a = 7'd20 + 7'($urandom_range(80));
            setp(0, a);
            st();
            for (j = 0; j < 3; j++) wr(8'($urandom));
            st();
            entry_inc = 1'b0;
            wr(8'($urandom));
            st();
            rd();
            st();
            entry_inc = 1'b1;
            setp(0, a);
            for (j = 0; j < 3; j++) rd();
            a = {1'b0, 3'($urandom), 3'd5};
            setp(1, a);
            wr(8'($urandom) & 8'hDF);
            setp(1, a);
            rd();
            setp(2, 7'h00);
            for (j = 0; j < 16; j++) wr(8'($urandom));
            host.idle();
            for (j = 0; j < 16; j++) want[79-5*j -: 5] = mem[2][j][4:0];
            // Whole frame precedes the icon row, so in four-line mode the upper commons show up first
            a[0] = 1'b0;
            j = 0;
            while (icon_com !== 2'b11 && j < 12000)
            begin
                @(negedge clk_sys);
                a[0] = a[0] | (|com_line[32:18]);
                j++;
            end
            chk(a[0], four_line);
            repeat (2) @(negedge clk_sys);
            chk(icon_com, 2'b11);
            chk(segment_line, want);
            @(posedge clk_sys);
            #1;
        end
        stop_test();
    end
endmodule : clagi_core_tb_top
`default_nettype wire

// ---- tb/clagi_host_model.sv ----
// Host processor model driving the bus and command inputs.
// Assumes callers enter each task one small delay after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module clagi_host_model
    import clagi_pkg::*;
(
    input  wire logic                 clk_sys,
    output var clagi_pkg::clagi_bus_s bus,
    output var clagi_pkg::clagi_cmd_s cmd
);
    initial
    begin
        bus = '0;
        cmd = '{1'b0, CLAGI_TGT_TEXT, 7'h00};
    end
    // One access per cycle, held through the sampling edge
    task automatic access(input logic rs, input logic rw, input logic [7:0] d);
        cmd.set_addr = 1'b0;
        bus = '{rs, rw, 1'b1, d};
        @(posedge clk_sys);
        #1;
    endtask : access
    task automatic set_ptr(input clagi_tgt_e t, input logic [6:0] a);
        bus.strobe = 1'b0;
        cmd = '{1'b1, t, a};
        @(posedge clk_sys);
        #1;
    endtask : set_ptr
    // Released data lines show the inverse, not the last value
    task automatic idle;
        bus.strobe = 1'b0;
        bus.data = ~bus.data;
        cmd.set_addr = 1'b0;
        @(posedge clk_sys);
        #1;
    endtask : idle
endmodule : clagi_host_model
`default_nettype wire

// ---- tb/clagi_properties.sv ----
// Port checker for the LCD address, glyph and icon datapath.
// Assumes it is bound onto clagi_core and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module clagi_properties
    import clagi_pkg::*;
(
    input wire logic                   clk_sys,
    input wire logic                   rst,
    input wire clagi_pkg::clagi_bus_s  bus,
    input wire clagi_pkg::clagi_cmd_s  cmd,
    input wire logic                   busy,
    input wire logic                   entry_inc,
    input wire logic                   four_line,
    input wire logic [7:0]             read_data,
    input wire logic [CLAGI_COM_N-1:0] com_line,
    input wire logic [1:0]             icon_com,
    input wire logic [CLAGI_SEG_N-1:0] segment_line
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Accepted requests; a same-cycle address set wins over an access
    wire st_rd = bus.strobe && !bus.rs && bus.rw && !cmd.set_addr;
    wire dt_acc = bus.strobe && bus.rs && !cmd.set_addr;
    property p_icon_same; icon_com[0] == icon_com[1]; endproperty
    a_icon_same: assert property (p_icon_same) else $error("icon commons differ");
    property p_com_one; $onehot0(com_line); endproperty
    a_com_one: assert property (p_com_one) else $error("more than one common on");
    property p_two_line; !four_line |-> com_line[33:18] == '0; endproperty
    a_two_line: assert property (p_two_line) else $error("upper common in two-line mode");
    property p_busy; st_rd |=> read_data[7] == $past(busy); endproperty
    a_busy: assert property (p_busy) else $error("busy bit wrong");
    property p_load;
        cmd.set_addr && cmd.tgt == CLAGI_TGT_TEXT ##1 st_rd |=> read_data[6:0] == $past(cmd.addr, 2);
    endproperty
    a_load: assert property (p_load) else $error("pointer not loaded");
    property p_step;
        st_rd ##1 dt_acc ##1 st_rd |=>
            read_data[6:0] == $past(read_data[6:0], 2) + ($past(entry_inc, 2) ? 7'h01 : 7'h7F);
    endproperty
    a_step: assert property (p_step) else $error("pointer step wrong");
    // Held latch must not move while its common stays on
    property p_seg_hold; |com_line && $stable(com_line) |-> $stable(segment_line); endproperty
    a_seg_hold: assert property (p_seg_hold) else $error("segments moved mid row");
    property p_row_moves; $rose(|com_line) |-> ##[1:300] $changed(com_line); endproperty
    a_row_moves: assert property (p_row_moves) else $error("common stuck");
    c_status: cover property (st_rd);
    c_upper: cover property (com_line[32]);
    c_icon: cover property (icon_com[0]);
endmodule : clagi_properties
bind clagi_core clagi_properties i_clagi_properties (.clk_sys(clk_sys), .rst(rst), .bus(bus), .cmd(cmd),
    .busy(busy), .entry_inc(entry_inc), .four_line(four_line), .read_data(read_data), .com_line(com_line),
    .icon_com(icon_com), .segment_line(segment_line));
`default_nettype wire
